/* logic/mdl_dev.sv */
`timescale 1ns/100ps
// Operation
// (R1) 19-bit frame: five address, fourteen code, MSB first
// (R2) Address picks one of 32 channels
// (R3) Code replaces the addressed channel register
// (R4) Update only after all nineteen bits arrive
// (R5) Codes are straight unsigned binary, 0 to 16383
// (R6) Every channel register holds zero at power-up
// (R7) Reset low clears every register
// (R8) Data sampled on shift-clock falling edge
// (R9) Frame-sync fall clears the bit counter
// (R10) Frame-sync edges ignored mid-frame
// (R11) Shift-clock ignored after nineteenth bit
// (R12) Each write needs a fresh frame-sync fall
// (R13) Host leaves 280 ns between writes
// (R14) Continuous or gated shift clock both work
// (R15) Shift logic handles fast shift clock; here two-stage sampling limits it to about a sixth of core_clk
// (R16) Byte hosts send three left-justified bytes
// (R17) Data shifts only while frame-sync is low
// (R18) Undriven shift-clock, data, reset read high; here frame-sync, shift-clock and data pull high, reset has no pull-up
// (R19) Reset also drops any partial frame
module mdl_dev
  import mdl_pkg::*;
(
  // Clock and reset pin
  input wire logic core_clk,
  input wire logic resetn,
  // Serial link from the host
  mdl_link_if.dev link,
  // Channel codes towards the converters
  output logic [NCH-1:0][CODE_W-1:0] channel_code,
  // Load notice and frame busy flag
  output logic load_strobe,
  output logic [ADDR_W-1:0] load_addr,
  output logic frame_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin
  // The pin clears everything at once, but its release is retimed through two
  // stages so that every flip-flop leaves reset on the same core_clk edge.
  // A frame begun meanwhile still shows as a fall, since the pin stages rest
  // at the pulled-up level while held.
  logic rst_meta;
  logic rst_sync;
  logic dev_rstn;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0; // R7
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign dev_rstn = rst_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, bit order {frame_n, sclk, din}
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_prev;

  // Stages reset to the pulled-up idle level so no false edge follows reset
  always_ff @(posedge core_clk or negedge dev_rstn) begin
    if (!dev_rstn) begin
      pin_meta <= PIN_IDLE; // R18
      pin_sync <= PIN_IDLE;
      pin_prev <= PIN_IDLE;
    end else begin
      pin_meta <= {link.frame_n, link.sclk, link.din};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  logic frame_low;
  logic frame_fall;
  logic sclk_fall;
  logic din_bit;

  assign frame_low = ~pin_sync[2];
  assign frame_fall = pin_prev[2] & ~pin_sync[2];
  // Edge seen from sampled levels, so a free-running clock is harmless
  assign sclk_fall = pin_prev[1] & ~pin_sync[1]; // R14
  // Data runs through the same two stages as the clock, so the bit taken at a
  // seen fall is the one that stood at the pin when the clock fell (R8)
  assign din_bit = pin_sync[0];

  ////////////////////////////////////////////////////////////////////////////
  // Frame receiver
  mdl_rx_state_t state, next_state;
  logic [CNT_W-1:0] bit_cnt, next_bit_cnt;
  logic [FRAME_BITS-1:0] shreg, next_shreg;
  logic [FRAME_BITS-1:0] shifted;
  logic next_load_strobe;
  logic [ADDR_W-1:0] next_load_addr;
  logic [CODE_W-1:0] load_code, next_load_code;

  assign shifted = {shreg[FRAME_BITS-2:0], din_bit}; // R1

  // The counter steps on to the frame size at the last bit; the move to the done state, not the count, ends shifting
  logic last_bit;
  assign last_bit = (bit_cnt == CNT_W'(FRAME_BITS - 1)); // R11

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_load_strobe = 1'b0;
    next_load_addr = load_addr;
    next_load_code = load_code;
    case (state)
      MDL_RX_IDLE: begin
        if (frame_fall) begin
          next_bit_cnt = '0; // R9
          next_shreg = '0;
          next_state = MDL_RX_SHIFT;
        end
      end
      MDL_RX_SHIFT: begin
        // A frame-sync fall here is not looked at (R10). A frame cut short
        // therefore resumes counting when frame-sync falls again; nothing
        // times it out, only reset drops it
        if (sclk_fall && frame_low) begin // R8 R17
          next_shreg = shifted;
          next_bit_cnt = bit_cnt + 5'h01;
          if (last_bit) begin
            // Whole frame in hand: only now release the load (R4)
            next_load_strobe = 1'b1;
            next_load_addr = shifted[FRAME_BITS-1:CODE_W]; // R2
            next_load_code = shifted[CODE_W-1:0]; // R5
            next_state = MDL_RX_DONE;
          end
        end
      end
      MDL_RX_DONE: begin
        // Trailing clocks, e.g. the last five of a byte host, are dropped (R11) (R16)
        if (frame_fall) begin // R12
          next_bit_cnt = '0; // R9
          next_shreg = '0;
          next_state = MDL_RX_SHIFT;
        end
      end
      default: begin
        next_state = MDL_RX_IDLE;
        next_bit_cnt = '0;
      end
    endcase
  end

  // A partial frame is abandoned by reset, not resumed (R19)
  always_ff @(posedge core_clk or negedge dev_rstn) begin
    if (!dev_rstn) begin
      state <= MDL_RX_IDLE; // R7 R19
      bit_cnt <= '0;
      shreg <= '0;
      load_strobe <= 1'b0;
      load_addr <= '0;
      load_code <= CODE_RST;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      load_strobe <= next_load_strobe;
      load_addr <= next_load_addr;
      load_code <= next_load_code;
    end
  end

  // Busy covers the counting phase only; trailing clocks after the last bit
  // leave it low
  assign frame_busy = (state == MDL_RX_SHIFT);

  ////////////////////////////////////////////////////////////////////////////
  // Channel registers
  // Each channel decodes its own select from the registered load notice, so
  // at most one register changes per load and none changes mid-frame
  logic [NCH-1:0] load_sel;
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_chan
      logic [CODE_W-1:0] next_code;

      assign load_sel[ch] = load_strobe && (load_addr == ADDR_W'(ch)); // R2

      always_comb begin
        next_code = channel_code[ch];
        if (load_sel[ch]) begin // R4
          next_code = load_code; // R3
        end
      end

      always_ff @(posedge core_clk or negedge dev_rstn) begin
        if (!dev_rstn) begin
          channel_code[ch] <= CODE_RST; // R6 R7
        end else begin
          channel_code[ch] <= next_code;
        end
      end
    end
  endgenerate

  // Sampling through two stages limits the shift clock to about a sixth of
  // core_clk; reaching the top link rate needs a faster core clock (R15)

endmodule

/* logic/mdl_pkg.sv */
package mdl_pkg;

  // Frame layout: address then code, most significant bit first
  localparam int NCH = 32;
  localparam int ADDR_W = 5;
  localparam int CODE_W = 14;
  localparam int FRAME_BITS = ADDR_W + CODE_W;
  localparam int BYTE_FRAME_BITS = 24;
  localparam int CNT_W = 5;

  // Channel register reset value
  localparam logic [CODE_W-1:0] CODE_RST = 14'h0000;

  // Idle level of every link pin after reset
  localparam logic [2:0] PIN_IDLE = 3'h7;

  // Core clock and link timing
  localparam int CORE_CLK_NS = 20;
  localparam int SCLK_HALF_CYC = 4;
  localparam int WRITE_GAP_NS = 280;
  localparam int WRITE_GAP_CYC = (WRITE_GAP_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

  // Device receive states
  typedef enum logic [1:0] {
    MDL_RX_IDLE = 2'b00,
    MDL_RX_SHIFT = 2'b01,
    MDL_RX_DONE = 2'b10
  } mdl_rx_state_t;

  // Host transmit states
  typedef enum logic [2:0] {
    MDL_TX_IDLE = 3'b000,
    MDL_TX_HIGH = 3'b001,
    MDL_TX_LOW = 3'b010,
    MDL_TX_GAP = 3'b011
  } mdl_tx_state_t;

endpackage

/* logic/mdl_link_if.sv */
`timescale 1ns/100ps
interface mdl_link_if;
  // Host drive side
  logic frame_n_drv;
  logic sclk_drv;
  logic din_drv;
  logic drv_en;
  // Pin levels as the device sees them; undriven pins pull high
  logic frame_n;
  logic sclk;
  logic din;

  assign frame_n = drv_en ? frame_n_drv : 1'b1;
  assign sclk = drv_en ? sclk_drv : 1'b1;
  assign din = drv_en ? din_drv : 1'b1;

  modport host (
    output frame_n_drv,
    output sclk_drv,
    output din_drv,
    output drv_en
  );

  modport dev (
    input frame_n,
    input sclk,
    input din
  );
endinterface

/* logic/mdl_host.sv */
`timescale 1ns/100ps
module mdl_host
  import mdl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Link to the device
  mdl_link_if.host link,
  // Write requests
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [CODE_W-1:0] req_code,
  input wire logic req_byte_mode
);

  mdl_tx_state_t state, next_state;
  logic [BYTE_FRAME_BITS-1:0] shreg, next_shreg;
  logic [CNT_W-1:0] bits_left, next_bits_left;
  logic [3:0] tick, next_tick;
  logic frame_n, next_frame_n;
  logic sclk, next_sclk;

  assign req_ready = (state == MDL_TX_IDLE);

  assign link.frame_n_drv = frame_n;
  assign link.sclk_drv = sclk;
  assign link.din_drv = shreg[BYTE_FRAME_BITS-1];
  assign link.drv_en = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_bits_left = bits_left;
    next_tick = tick;
    next_frame_n = frame_n;
    next_sclk = sclk;
    case (state)
      MDL_TX_IDLE: begin
        if (req_valid) begin
          // Payload is left-justified so extra byte bits trail the frame (R1) (R16)
          next_shreg = {req_addr, req_code, 5'h00};
          next_bits_left = req_byte_mode ? CNT_W'(BYTE_FRAME_BITS) : CNT_W'(FRAME_BITS); // R16
          next_frame_n = 1'b0; // R17
          next_sclk = 1'b1;
          next_tick = 4'h0;
          next_state = MDL_TX_HIGH;
        end
      end
      MDL_TX_HIGH: begin
        next_tick = tick + 4'h1;
        if (tick == 4'(SCLK_HALF_CYC - 1)) begin
          // Falling edge lands mid-bit, data held stable around it (R8)
          next_sclk = 1'b0;
          next_tick = 4'h0;
          next_bits_left = bits_left - 5'h01;
          next_state = MDL_TX_LOW;
        end
      end
      MDL_TX_LOW: begin
        next_tick = tick + 4'h1;
        if (tick == 4'(SCLK_HALF_CYC - 1)) begin
          next_tick = 4'h0;
          next_sclk = 1'b1;
          if (bits_left == 5'h00) begin
            // Raise frame sync so the next write needs a fresh fall (R12)
            next_frame_n = 1'b1;
            next_state = MDL_TX_GAP;
          end else begin
            next_shreg = {shreg[BYTE_FRAME_BITS-2:0], 1'b0};
            next_state = MDL_TX_HIGH;
          end
        end
      end
      MDL_TX_GAP: begin
        next_tick = tick + 4'h1;
        if (tick == 4'(WRITE_GAP_CYC - 1)) begin // R13
          next_tick = 4'h0;
          next_state = MDL_TX_IDLE;
        end
      end
      default: begin
        next_state = MDL_TX_IDLE;
        next_frame_n = 1'b1;
        next_sclk = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= MDL_TX_IDLE;
      shreg <= '0;
      bits_left <= '0;
      tick <= '0;
      frame_n <= 1'b1;
      sclk <= 1'b1;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      bits_left <= next_bits_left;
      tick <= next_tick;
      frame_n <= next_frame_n;
      sclk <= next_sclk;
    end
  end

endmodule

/* test/mdl_link_assertions.sv */
`timescale 1ns/100ps
module mdl_link_assertions
  import mdl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Link pins
  input wire logic frame_n,
  input wire logic sclk,
  input wire logic din
);
  logic sclk_q;
  logic [4:0] hi_cnt;
  logic [4:0] fall_cnt;
  logic [4:0] next_hi_cnt;
  logic [4:0] next_fall_cnt;

  // Saturates so a long idle spell never wraps below the gap limit
  always_comb begin
    next_hi_cnt = frame_n ? hi_cnt + {4'h0, hi_cnt != 5'h1F} : 5'h00;
    next_fall_cnt = frame_n ? 5'h00 : fall_cnt + {4'h0, sclk_q & ~sclk};
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_q <= 1'b1;
      hi_cnt <= 5'h1F;
      fall_cnt <= 5'h00;
    end else begin
      sclk_q <= sclk;
      hi_cnt <= next_hi_cnt;
      fall_cnt <= next_fall_cnt;
    end
  end

  ////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  gated_clock_a: assert property (frame_n |-> sclk)
    else $error("shift clock moved outside a frame");
  low_half_a: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
    else $error("shift clock low phase wrong");
  data_hold_a: assert property (!sclk |-> $stable(din))
    else $error("data moved while shift clock low");
  first_fall_a: assert property ($fell(frame_n) |-> sclk [*4] ##1 !sclk)
    else $error("first shift edge misplaced");
  write_gap_a: assert property ($fell(frame_n) |-> int'(hi_cnt) >= WRITE_GAP_CYC)
    else $error("gap between writes too short");
  frame_len_a: assert property ($rose(frame_n) |-> fall_cnt == 5'h13 || fall_cnt == 5'h18)
    else $error("wrong number of shift edges");
  frame_end_a: assert property ($rose(frame_n) |-> $rose(sclk))
    else $error("frame did not end after last bit");
  frame_span_a: assert property ($fell(frame_n) |-> ##[152:192] $rose(frame_n))
    else $error("frame length out of range");

  cover property ($rose(frame_n) && fall_cnt == 5'h13);
  cover property ($rose(frame_n) && fall_cnt == 5'h18);
  cover property ($fell(frame_n) ##1 !frame_n);
endmodule

/* test/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import mdl_pkg::*;
  logic core_clk, resetn, req_valid, req_ready, req_byte_mode, load_strobe, load_strobe2;
  logic frame_busy;
  logic [ADDR_W-1:0] req_addr, load_addr, load_addr2;
  logic [CODE_W-1:0] req_code;
  logic [NCH-1:0][CODE_W-1:0] channel_code, channel_code2;
  int n_fail, cmp_count, loads2;
  int model[NCH], model2[NCH];
  mdl_link_if link();
  mdl_link_if link2();

  mdl_host mdl_host_inst(.core_clk(core_clk), .resetn(resetn), .link(link),
    .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
    .req_code(req_code), .req_byte_mode(req_byte_mode));
  mdl_dev mdl_dev_inst(.core_clk(core_clk), .resetn(resetn), .link(link),
    .channel_code(channel_code), .load_strobe(load_strobe), .load_addr(load_addr),
    .frame_busy(frame_busy));
  // Second device driven by a bench host that breaks the framing on purpose
  mdl_dev mdl_dev_inst2(.core_clk(core_clk), .resetn(resetn), .link(link2),
    .channel_code(channel_code2), .load_strobe(load_strobe2), .load_addr(load_addr2),
    .frame_busy());
  mdl_link_assertions mdl_link_assertions_inst(.core_clk(core_clk), .resetn(resetn),
    .frame_n(link.frame_n), .sclk(link.sclk), .din(link.din));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(negedge core_clk) begin
    if (load_strobe2 === 1'b1) loads2++;
  end

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic check_all(input logic [NCH-1:0][CODE_W-1:0] seen, input int exp[NCH]);
    for (int i = 0; i < NCH; i++) begin
      check(seen[i], exp[i]);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic write_one(input logic [ADDR_W-1:0] a, input logic [CODE_W-1:0] c);
    int t;
    t = 0;
    while (req_ready !== 1'b1 && t < 500) begin
      @(negedge core_clk);
      t++;
    end
    req_addr = a;
    req_code = c;
    req_byte_mode = 1'($urandom);
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    repeat (8) @(negedge core_clk);
    check(frame_busy, 1'b1);
    while (load_strobe !== 1'b1 && t < 800) begin
      @(negedge core_clk);
      t++;
    end
    check(load_strobe, 1'b1);
    check(frame_busy, 1'b0);
    check(load_addr, a);
    check(channel_code[a], model[a]);
    model[a] = c;
    @(negedge core_clk);
    check_all(channel_code, model);
  endtask

  // Bench shift clock: 160 ns period, data set while high
  task automatic bits2(input logic [18:0] w, input int hi, input int lo);
    for (int i = hi; i >= lo; i--) begin
      link2.din_drv = w[i];
      #80 link2.sclk_drv = 1'b0;
      #80 link2.sclk_drv = 1'b1;
    end
  endtask

  ////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req_addr = 5'h00;
    req_code = 14'h0000;
    req_byte_mode = 1'b0;
    link2.drv_en = 1'b0;
    link2.frame_n_drv = 1'b1;
    link2.sclk_drv = 1'b1;
    link2.din_drv = 1'b1;
    void'($urandom(31));
    repeat (5) @(negedge core_clk);
    check_all(channel_code, model);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    write_one(5'h00, 14'h0000);
    write_one(5'h1F, 14'h3FFF);
    for (int i = 0; i < 24; i++) begin
      write_one(5'($urandom), 14'($urandom));
    end
    req_addr = 5'h0A;
    req_code = 14'h1555;
    req_valid = 1'b1;
    repeat (30) @(negedge core_clk);
    req_valid = 1'b0;
    repeat (50) @(negedge core_clk);
    resetn = 1'b0;
    repeat (5) @(negedge core_clk);
    foreach (model[i]) model[i] = 0;
    check_all(channel_code, model);
    check(frame_busy, 1'b0);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    write_one(5'h0B, 14'h2AAA);
    link2.drv_en = 1'b1;
    link2.frame_n_drv = 1'b0;
    bits2({5'h03, 14'h2345}, 18, 10);
    link2.frame_n_drv = 1'b1;
    #200 link2.frame_n_drv = 1'b0;
    bits2({5'h03, 14'h2345}, 9, 0);
    bits2(19'h7FFFF, 4, 0);
    link2.frame_n_drv = 1'b1;
    bits2(19'h00000, 4, 0);
    model2[3] = 14'h2345;
    link2.frame_n_drv = 1'b0;
    bits2({5'h04, 14'h1111}, 18, 9);
    link2.frame_n_drv = 1'b1;
    #400 link2.frame_n_drv = 1'b0;
    bits2({5'h05, 14'h0ABC}, 18, 0);
    link2.frame_n_drv = 1'b1;
    // The fall after the cut is ignored mid-frame, so ten bits of the first word
    // and nine of the second make one frame: channel 4, code 14'h1052
    model2[4] = 14'h1052;
    link2.drv_en = 1'b0;
    repeat (8) @(negedge core_clk);
    check(loads2, 2);
    check_all(channel_code2, model2);
    check(load_addr2, 5'h04);
    stop_test();
  end

  // About 30 writes of up to 230 cycles each, with ample margin
  initial begin
    #400000;
    n_fail++;
    stop_test();
  end
endmodule
